// ### bench/pulse_source.sv
`timescale 1ns/1ps
// ==========================================
// Encoder and pulse source on the four counter inputs
module pulse_source #(
	parameter int GAP_CYC = 12_500
) (
	input  wire logic       clk,
	output logic      [3:0] pin
);
	initial pin = 4'h0;

	task automatic drive(input int i, input logic v, input int hold);
		@(posedge clk);
		pin[i] <= v;
		repeat (hold - 1) @(posedge clk);
	endtask

	// Edge spacing is a parameter: the bench shortens it, only the sync delay matters
	task automatic set_pin(input int i, input logic v);
		drive(i, v, GAP_CYC);
	endtask

	task automatic pulse(input int i, input int hi, input int lo, input int n);
		repeat (n) begin
			drive(i, 1'b1, hi);
			drive(i, 1'b0, lo);
		end
	endtask

	// One Gray step on pair p/p+1; a single phase moves so no step is ambiguous
	task automatic quad_step(input int p, input bit fwd);
		if (fwd ^ (pin[p] ^ pin[p+1]))
			set_pin(p, ~pin[p]);
		else
			set_pin(p + 1, ~pin[p+1]);
	endtask
endmodule

// ### bench/tb_high_speed_counter_quadrature.sv
`timescale 1ns/1ps
// ==========================================
// Bench for the four-channel counter
module tb_high_speed_counter_quadrature;
	localparam int GAP = 20;
	localparam int TK = hsc_pkg::TICK_CYC;
	localparam int LIM = hsc_pkg::HWRST_LAT_US * TK / 2;
	localparam int WIN [4] = '{4, 10, 20, 50};
	localparam logic [7:0] CFG = hsc_pkg::CFG_BASE;
	localparam logic [7:0] ACC = hsc_pkg::ACC_BASE;
	localparam logic [7:0] CTL = hsc_pkg::CTRL_OFS;
	localparam logic [7:0] PRE = hsc_pkg::PRESET_BASE;
	localparam logic [31:0] QUP = 32'h0000_0001 << hsc_pkg::CFG_QUP_BIT;
	localparam logic [31:0] MLVL = 32'h0000_0001 << hsc_pkg::CFG_MLVL_BIT;
	localparam logic [31:0] FSEL = 32'h0000_0001 << hsc_pkg::CFG_MFALL_BIT;
	localparam logic [31:0] CMPEN = 32'h0000_0001 << hsc_pkg::CFG_CMPEN_BIT;
	localparam logic [31:0] Z = 32'h0000_0000;

	typedef struct {
		int                ch;
		hsc_pkg::mode_type mode;
		logic [1:0]        sub;
		logic [31:0]       x;
		int                md;
		int                n;
		bit                fwd;
		logic [31:0]       res;
	} row_type;

	// Channel, mode, sub, extra bits, modulus, steps, direction, result
	row_type rows [9] = '{
		'{0, hsc_pkg::M_TOTAL, 2'h0, Z, 0, 5, 1'b1, 32'h0000_0005},
		'{1, hsc_pkg::M_TOTAL, 2'h1, Z, 0, 3, 1'b1, 32'h0000_0003},
		'{3, hsc_pkg::M_TOTAL, 2'h0, Z, 4, 6, 1'b1, 32'h0000_0002},
		'{2, hsc_pkg::M_TOTAL, 2'h0, Z, 3, 3, 1'b1, 32'h0000_0000},
		'{0, hsc_pkg::M_QUAD, 2'h0, QUP, 0, 3, 1'b1, 32'h0000_0003},
		'{0, hsc_pkg::M_QUAD, 2'h0, QUP, 8, 2, 1'b0, 32'h0000_0006},
		'{0, hsc_pkg::M_QUAD, 2'h0, QUP, 8, 9, 1'b1, 32'h0000_0001},
		'{2, hsc_pkg::M_QUAD, 2'h0, Z, 0, 4, 1'b1, 32'hFFFF_FFFC},
		'{2, hsc_pkg::M_QUAD, 2'h0, QUP, 0, 1, 1'b0, 32'hFFFF_FFFF}
	};

	logic        clk;
	logic        rst_n;
	logic [3:0]  pin;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr_stb;
	logic        rd_stb;
	logic [31:0] rdata_r;
	logic        cmp_one;
	logic        cmp_two;
	logic [31:0] rv;
	row_type     rw;
	int          n_errors;
	int          cmp_count;

	high_speed_counter_quadrature #(
		.WIN0_US(WIN[0]), .WIN1_US(WIN[1]), .WIN2_US(WIN[2]), .WIN3_US(WIN[3])
	) u_high_speed_counter_quadrature (
		.clk(clk), .rst_n(rst_n), .input_one_pin(pin[0]), .input_two_pin(pin[1]),
		.input_three_pin(pin[2]), .input_four_pin(pin[3]), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_r(rdata_r),
		.compare_output_one_r(cmp_one), .compare_output_two_r(cmp_two)
	);

	pulse_source #(.GAP_CYC(GAP)) u_pulse_source (.clk(clk), .pin(pin));

	initial clk = 1'b0;
	always #4 clk = ~clk;

	// ==========================================
	// Tasks
	task automatic final_report();
		if (n_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		#1;
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chk_near(input string nm, input int e, input int t, input logic [31:0] g);
		logic ok;
		ok = (g >= 32'(e - t)) && (g <= 32'(e + t));
		cmp_count++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("ERROR %s expected %0d within %0d seen %0d", nm, e, t, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		rv = rdata_r;
	endtask

	task automatic chk_acc(input int ch, input logic [31:0] e);
		rd(ACC + 8'(4 * ch));
		chk("accumulator", e, rv);
	endtask

	// Bounded poll: running out of reads ends the run
	task automatic poll(input int ch, input logic [31:0] e);
		int k;
		k = 0;
		rv = ~e;
		while (rv !== e && k < LIM) begin
			rd(ACC + 8'(4 * ch));
			k++;
		end
		chk("accumulator poll", e, rv);
		if (rv !== e)
			final_report();
	endtask

	function automatic logic [31:0] cfgw(hsc_pkg::mode_type m, logic [1:0] s, logic [31:0] x);
		return (32'(m) << hsc_pkg::CFG_MODE_LSB) | (32'(s) << hsc_pkg::CFG_SUB_LSB) | x;
	endfunction

	task automatic setup(input int ch, input logic [31:0] c, input int md);
		wr(CFG + 8'(4 * ch), c);
		wr(hsc_pkg::MOD_BASE + 8'(4 * ch), 32'(md));
		wr(CTL, 32'h0000_0001 << ch);
		wr(CTL, Z);
	endtask

	initial begin
		#(8 * 100_000);
		n_errors++;
		final_report();
	end

	// ==========================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		addr = 8'h00;
		wdata = Z;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		n_errors = 0;
		cmp_count = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			chk_acc(c, Z);
			rd(CFG + 8'(4 * c));
			chk("config", 32'(hsc_pkg::CFG_RESET), rv);
		end
		rd(8'h44);
		chk("unmapped read", Z, rv);
		chk_bit("compare one", 1'b0, cmp_one);
		chk_bit("compare two", 1'b0, cmp_two);
		foreach (rows[r]) begin
			rw = rows[r];
			setup(rw.ch, cfgw(rw.mode, rw.sub, rw.x), rw.md);
			repeat (rw.n)
				if (rw.mode == hsc_pkg::M_QUAD)
					u_pulse_source.quad_step(rw.ch, rw.fwd);
				else
					u_pulse_source.pulse(rw.ch, GAP, GAP, 1);
			chk_acc(rw.ch, rw.res);
		end
		@(posedge clk);
		#1;
		chk("read data after", Z, rdata_r);
		for (int c = 0; c < 4; c++) begin
			wr(CFG + 8'(4 * c), Z);
			if (pin[c])
				u_pulse_source.set_pin(c, 1'b0);
		end
		// Compare outputs against a preset changed at run time
		setup(0, cfgw(hsc_pkg::M_TOTAL, 2'h0, CMPEN), 0);
		wr(PRE, 32'h0000_0003);
		u_pulse_source.pulse(0, GAP, GAP, 2);
		chk_bit("compare one", 1'b0, cmp_one);
		u_pulse_source.pulse(0, GAP, GAP, 1);
		chk_bit("compare one", 1'b1, cmp_one);
		wr(PRE, Z);
		repeat (3) @(posedge clk);
		chk_bit("compare one", 1'b0, cmp_one);
		wr(PRE, 32'h0000_0004);
		u_pulse_source.pulse(0, GAP, GAP, 1);
		chk_bit("compare one", 1'b1, cmp_one);
		setup(1, cfgw(hsc_pkg::M_TOTAL, 2'h0, CMPEN), 0);
		wr(PRE + 8'h04, 32'h0000_0001);
		u_pulse_source.pulse(1, GAP, GAP, 1);
		chk_bit("compare two", 1'b1, cmp_two);
		// Clear bit is a level: edges while it is set are lost
		wr(CTL, 32'h0000_0001);
		u_pulse_source.pulse(0, GAP, GAP, 2);
		chk_acc(0, Z);
		wr(CTL, Z);
		u_pulse_source.pulse(0, GAP, GAP, 1);
		chk_acc(0, 32'h0000_0001);
		// Hardware resets: rising on input three, falling on input four
		wr(CFG + 8'h08, cfgw(hsc_pkg::M_TRESET, 2'h0, Z));
		u_pulse_source.set_pin(2, 1'b1);
		poll(0, Z);
		u_pulse_source.set_pin(2, 1'b0);
		wr(CFG + 8'h0C, cfgw(hsc_pkg::M_TRESET, 2'h1, Z));
		u_pulse_source.set_pin(3, 1'b1);
		chk_acc(1, 32'h0000_0001);
		u_pulse_source.set_pin(3, 1'b0);
		poll(1, Z);
		for (int s = 0; s < 4; s++) begin
			setup(1, cfgw(hsc_pkg::M_PULSE, 2'(s), Z), 0);
			u_pulse_source.pulse(1, 5 * TK, 3 * TK, 3);
			rd(ACC + 8'h04);
			chk_near("pulse", (s == 0) ? 5 : (s == 1) ? 3 : 8, 1, rv);
		end
		// A 500 kHz input; one edge more or less is the window's resolution
		for (int s = 0; s < 4; s++) begin
			setup(0, cfgw(hsc_pkg::M_FREQ, 2'(s), Z), 0);
			u_pulse_source.pulse(0, TK, TK, WIN[s]);
			rd(ACC);
			chk_near("frequency", 500_000, 1_000_000 / WIN[s], rv);
		end
		setup(0, cfgw(hsc_pkg::M_QUAD, 2'h0, QUP), 8);
		wr(CTL, 32'h0000_0002);
		chk_acc(0, 32'h0000_0007);
		wr(CTL, 32'h0000_0003);
		chk_acc(0, Z);
		setup(2, cfgw(hsc_pkg::M_QUAD, 2'h0, QUP), 5);
		wr(CTL, 32'h0000_0008);
		wr(CTL, Z);
		chk_acc(2, 32'h0000_0004);
		for (int s = 0; s < 3; s++) begin
			setup(0, cfgw(hsc_pkg::M_QUAD, 2'h0, QUP), 0);
			wr(CFG + 8'h08, cfgw(hsc_pkg::M_MARKER, 2'(s), Z));
			repeat (3) u_pulse_source.quad_step(0, 1'b1);
			u_pulse_source.set_pin(2, 1'b1);
			chk_acc(0, (s == 1) ? 32'h0000_0003 : Z);
			u_pulse_source.set_pin(2, 1'b0);
			chk_acc(0, Z);
		end
		for (int f = 0; f < 2; f++) begin
			repeat (4)
				if (pin[1:0] !== 2'h0)
					u_pulse_source.quad_step(0, 1'b1);
			setup(0, cfgw(hsc_pkg::M_QUAD, 2'h0, QUP), 8);
			wr(CFG + 8'h08, cfgw(hsc_pkg::M_MARKER, 2'h3, MLVL | (f ? FSEL : Z)));
			u_pulse_source.set_pin(2, 1'b1);
			rd(hsc_pkg::STAT_OFS);
			chk("synced levels", 32'h0000_0004, {28'h000_0000, rv[5:2]});
			u_pulse_source.quad_step(0, 1'b1);
			chk_acc(0, f ? 32'h0000_0007 : Z);
			u_pulse_source.set_pin(2, 1'b0);
			repeat (3) u_pulse_source.quad_step(0, 1'b1);
			repeat (3) u_pulse_source.quad_step(0, 1'b0);
			u_pulse_source.set_pin(2, 1'b1);
			u_pulse_source.quad_step(0, 1'b0);
			chk_acc(0, f ? Z : 32'h0000_0007);
			u_pulse_source.set_pin(2, 1'b0);
		end
		final_report();
	end
endmodule

// ### rtl/high_speed_counter_quadrature.sv
// Functional notes
// R1 - Frequency mode writes hertz, four windows
// R2 - Shorter window: faster, coarser, higher minimum
// R3 - Totalize counts one per configured edge
// R4 - Totalize wraps at modulus, zero means full
// R5 - Program clear holds totalizer at zero
// R6 - Inputs three/four reset totalizers one/two
// R7 - Hardware reset zeroes within 100 us
// R8 - Compare output high when count reaches preset
// R9 - Preset changeable; zero preset forces low
// R10 - Width sub-modes report high/low microseconds
// R11 - Period sub-modes report edge-to-edge microseconds
// R12 - Quadrature on channels one and three only
// R13 - Four counts per cycle, reverse counts down
// R14 - Option picks up/down when A leads
// R15 - Quadrature wraps both ways at modulus
// R16 - Program bits clear or set quadrature
// R17 - Input three marker loads zero or modulus-1
// R18 - Async marker zeroes on chosen marker edge
// R19 - Sync marker acts on phase edge, level
// R20 - Falling-select sync: clockwise loads modulus-1
// R21 - Marker sampled within 50 us of edge
// R22 - Encoder marker spans one selected edge only
// R23 - Sources keep edges 100 us apart
// R24 - Inputs synchronised and edge-detected first
// R25 - Microsecond tick; 32-bit accumulators reset
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module high_speed_counter_quadrature #(
	parameter int ACC_W   = 32,
	parameter int WIN0_US = 10_000,
	parameter int WIN1_US = 100_000,
	parameter int WIN2_US = 500_000,
	parameter int WIN3_US = 1_000_000
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       input_one_pin,
	input  wire logic                       input_two_pin,
	input  wire logic                       input_three_pin,
	input  wire logic                       input_four_pin,
	input  wire logic [hsc_pkg::ADDR_W-1:0] addr,
	input  wire logic [hsc_pkg::DATA_W-1:0] wdata,
	input  wire logic                       wr_stb,
	input  wire logic                       rd_stb,
	output logic      [hsc_pkg::DATA_W-1:0] rdata_r,
	output logic                            compare_output_one_r,
	output logic                            compare_output_two_r
);
	localparam int N = hsc_pkg::NCH;

	logic [N-1:0]                    lvl;
	logic [N-1:0]                    rise;
	logic [N-1:0]                    fall;
	logic [hsc_pkg::CFG_W-1:0]       cfg_r [N];
	logic [ACC_W-1:0]                mod_r [N];
	logic [ACC_W-1:0]                preset_r [2];
	logic [N-1:0]                    prog_ctrl_r;
	logic [ACC_W-1:0]                acc_r [N];
	logic [ACC_W-1:0]                cnt_r [N];
	logic [ACC_W-1:0]                edges_r [N];
	logic [7:0]                      div_r;
	logic                            tick_r;
	hsc_pkg::mode_type               mode [N];
	logic [1:0]                      sub [N];
	logic [N-1:0]                    tot_ev;
	logic [N-1:0]                    hw_rst;
	logic [N-1:0]                    q_up;
	logic [N-1:0]                    q_dn;
	logic [N-1:0]                    win_end;
	logic [N-1:0]                    p_start;
	logic [N-1:0]                    p_stop;
	logic                            mk_ld;
	logic                            mk_zero;
	logic [1:0]                      grp_idx;

	// ==========================================================
	// Helpers
	function automatic logic [ACC_W-1:0] wrap_inc(input logic [ACC_W-1:0] a,
	                                              input logic [ACC_W-1:0] m);
		wrap_inc = (m != '0 && a == m - 1'b1) ? '0 : a + 1'b1;
	endfunction

	function automatic logic [ACC_W-1:0] wrap_dec(input logic [ACC_W-1:0] a,
	                                              input logic [ACC_W-1:0] m);
		// A zero modulus gives all ones, the full range
		wrap_dec = (a == '0) ? m - 1'b1 : a - 1'b1;
	endfunction

	function automatic logic [ACC_W-1:0] win_len(input logic [1:0] s);
		unique case (s)
			2'h0: win_len = ACC_W'(WIN0_US);
			2'h1: win_len = ACC_W'(WIN1_US);
			2'h2: win_len = ACC_W'(WIN2_US);
			2'h3: win_len = ACC_W'(WIN3_US);
		endcase
	endfunction

	function automatic logic [ACC_W-1:0] win_scale(input logic [1:0] s);
		win_scale = ACC_W'(hsc_pkg::US_PER_SEC) / win_len(s);
	endfunction

	// ==========================================================
	// Input conditioning
	hsc_in_sync #(
		.WIDTH (N)
	) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.pin     ({input_four_pin, input_three_pin, input_two_pin, input_one_pin}),
		.level_r (lvl),
		.rise_r  (rise),
		.fall_r  (fall)
	);

	// ==========================================================
	// Microsecond timebase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else if (div_r == 8'(hsc_pkg::TICK_CYC - 1)) begin
			div_r  <= '0;
			tick_r <= 1'b1; // see R25
		end else begin
			div_r  <= div_r + 8'h01;
			tick_r <= 1'b0;
		end
	end

	// ==========================================================
	// Event decode
	always_comb begin
		logic a_ev;
		logic b_ev;
		logic up;
		logic ph_r;
		logic ph_f;
		a_ev = 1'b0;
		b_ev = 1'b0;
		up   = 1'b0;
		ph_r = 1'b0;
		ph_f = 1'b0;
		for (int i = 0; i < N; i++) begin
			mode[i]    = hsc_pkg::mode_type'(cfg_r[i][hsc_pkg::CFG_MODE_LSB +: hsc_pkg::CFG_MODE_W]);
			sub[i]     = cfg_r[i][hsc_pkg::CFG_SUB_LSB +: hsc_pkg::CFG_SUB_W];
			tot_ev[i]  = sub[i][0] ? fall[i] : rise[i]; // see R3
			hw_rst[i]  = 1'b0;
			q_up[i]    = 1'b0;
			q_dn[i]    = 1'b0;
			win_end[i] = tick_r && cnt_r[i] == win_len(sub[i]) - 1'b1; // see R1
			p_start[i] = 1'b0;
			p_stop[i]  = 1'b0;
			unique case (hsc_pkg::pulse_type'(sub[i]))
				hsc_pkg::P_WHIGH: begin
					p_start[i] = rise[i]; // see R10
					p_stop[i]  = fall[i];
				end
				hsc_pkg::P_WLOW: begin
					p_start[i] = fall[i];
					p_stop[i]  = rise[i];
				end
				hsc_pkg::P_PRISE: begin
					p_start[i] = rise[i]; // see R11
					p_stop[i]  = rise[i];
				end
				hsc_pkg::P_PFALL: begin
					p_start[i] = fall[i];
					p_stop[i]  = fall[i];
				end
			endcase
		end
		for (int i = 0; i < 2; i++) begin
			hw_rst[i] = mode[i+2] == hsc_pkg::M_TRESET
			         && (sub[i+2][0] ? fall[i+2] : rise[i+2]); // see R6
		end
		for (int i = 0; i < N; i += 2) begin
			a_ev = rise[i] | fall[i];
			b_ev = rise[i+1] | fall[i+1];
			up   = a_ev ? (lvl[i] ^ lvl[i+1]) : ~(lvl[i] ^ lvl[i+1]); // see R13
			up   = cfg_r[i][hsc_pkg::CFG_QUP_BIT] ? up : ~up; // see R14
			// Both phases moving at once is not a legal step
			q_up[i] = mode[i] == hsc_pkg::M_QUAD && (a_ev ^ b_ev) && up; // see R12
			q_dn[i] = mode[i] == hsc_pkg::M_QUAD && (a_ev ^ b_ev) && !up;
		end
		// Marker on input three serves quadrature channel one only
		ph_r    = cfg_r[2][hsc_pkg::CFG_MPH_BIT] ? rise[1] : rise[0];
		ph_f    = cfg_r[2][hsc_pkg::CFG_MPH_BIT] ? fall[1] : fall[0];
		mk_ld   = 1'b0;
		mk_zero = 1'b1;
		if (mode[0] == hsc_pkg::M_QUAD && mode[2] == hsc_pkg::M_MARKER) begin // see R17
			unique case (hsc_pkg::marker_type'(sub[2]))
				hsc_pkg::MK_RISE: mk_ld = rise[2]; // see R18
				hsc_pkg::MK_FALL: mk_ld = fall[2];
				hsc_pkg::MK_BOTH: mk_ld = rise[2] | fall[2];
				hsc_pkg::MK_SYNC: begin
					// Marker level is read at the phase edge itself
					mk_ld   = (ph_r | ph_f) && lvl[2] == cfg_r[2][hsc_pkg::CFG_MLVL_BIT]; // see R19 R21
					mk_zero = ph_r ^ cfg_r[2][hsc_pkg::CFG_MFALL_BIT]; // see R20
				end
			endcase
		end
	end

	// ==========================================================
	// Accumulators
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				acc_r[i] <= '0; // see R25
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				unique case (mode[i])
					hsc_pkg::M_TOTAL: begin
						if (prog_ctrl_r[i] || hw_rst[i]) begin
							acc_r[i] <= '0; // see R5 R7
						end else if (tot_ev[i]) begin
							acc_r[i] <= wrap_inc(acc_r[i], mod_r[i]); // see R4
						end
					end
					hsc_pkg::M_QUAD: begin
						if (prog_ctrl_r[i]) begin
							acc_r[i] <= '0; // see R16
						end else if (prog_ctrl_r[(i+1)%N]) begin
							acc_r[i] <= mod_r[i] - 1'b1;
						end else if (i == 0 && mk_ld) begin
							acc_r[i] <= mk_zero ? '0 : mod_r[i] - 1'b1;
						end else if (q_up[i]) begin
							acc_r[i] <= wrap_inc(acc_r[i], mod_r[i]); // see R15
						end else if (q_dn[i]) begin
							acc_r[i] <= wrap_dec(acc_r[i], mod_r[i]);
						end
					end
					hsc_pkg::M_FREQ: begin
						if (win_end[i]) begin
							// Short windows lose resolution by the scale step
							acc_r[i] <= ACC_W'(edges_r[i] * win_scale(sub[i])); // see R1 R2
						end
					end
					hsc_pkg::M_PULSE: begin
						if (p_stop[i]) begin
							acc_r[i] <= cnt_r[i]; // see R10 R11
						end
					end
					default: acc_r[i] <= '0;
				endcase
			end
		end
	end

	// ==========================================================
	// Window and pulse timers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				cnt_r[i]   <= '0;
				edges_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				if (mode[i] == hsc_pkg::M_FREQ) begin
					if (win_end[i]) begin
						cnt_r[i]   <= '0;
						edges_r[i] <= ACC_W'(rise[i]);
					end else begin
						cnt_r[i]   <= cnt_r[i] + ACC_W'(tick_r);
						edges_r[i] <= edges_r[i] + ACC_W'(rise[i]);
					end
				end else if (mode[i] == hsc_pkg::M_PULSE) begin
					edges_r[i] <= '0;
					cnt_r[i]   <= p_start[i] ? '0 : cnt_r[i] + ACC_W'(tick_r); // see R25
				end else begin
					cnt_r[i]   <= '0;
					edges_r[i] <= '0;
				end
			end
		end
	end

	// ==========================================================
	// Compare outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			compare_output_one_r <= 1'b0;
			compare_output_two_r <= 1'b0;
		end else begin
			compare_output_one_r <= mode[0] == hsc_pkg::M_TOTAL
			                     && cfg_r[0][hsc_pkg::CFG_CMPEN_BIT]
			                     && preset_r[0] != '0 && acc_r[0] >= preset_r[0]; // see R8 R9
			compare_output_two_r <= mode[1] == hsc_pkg::M_TOTAL
			                     && cfg_r[1][hsc_pkg::CFG_CMPEN_BIT]
			                     && preset_r[1] != '0 && acc_r[1] >= preset_r[1];
		end
	end

	// ==========================================================
	// Register writes
	assign grp_idx = addr[3:2];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				cfg_r[i] <= hsc_pkg::CFG_RESET;
				mod_r[i] <= '0;
			end
			preset_r[0] <= '0;
			preset_r[1] <= '0;
			prog_ctrl_r <= '0;
		end else if (wr_stb && addr[1:0] == 2'b00) begin
			if (addr[7:4] == hsc_pkg::CFG_BASE[7:4]) begin
				cfg_r[grp_idx] <= wdata[hsc_pkg::CFG_W-1:0];
			end else if (addr[7:4] == hsc_pkg::MOD_BASE[7:4]) begin
				mod_r[grp_idx] <= wdata[ACC_W-1:0];
			end else if (addr == hsc_pkg::CTRL_OFS) begin
				prog_ctrl_r <= wdata[N-1:0];
			end else if (addr[7:4] == hsc_pkg::PRESET_BASE[7:4] && !grp_idx[1]) begin
				preset_r[grp_idx[0]] <= wdata[ACC_W-1:0]; // see R9
			end
		end
	end

	// ==========================================================
	// Register reads, data in the following cycle only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_r <= '0;
		end else if (!rd_stb || addr[1:0] != 2'b00) begin
			rdata_r <= '0;
		end else if (addr[7:4] == hsc_pkg::CFG_BASE[7:4]) begin
			rdata_r <= hsc_pkg::DATA_W'(cfg_r[grp_idx]);
		end else if (addr[7:4] == hsc_pkg::MOD_BASE[7:4]) begin
			rdata_r <= hsc_pkg::DATA_W'(mod_r[grp_idx]);
		end else if (addr == hsc_pkg::CTRL_OFS) begin
			rdata_r <= hsc_pkg::DATA_W'(prog_ctrl_r);
		end else if (addr[7:4] == hsc_pkg::PRESET_BASE[7:4] && !grp_idx[1]) begin
			rdata_r <= hsc_pkg::DATA_W'(preset_r[grp_idx[0]]);
		end else if (addr[7:4] == hsc_pkg::ACC_BASE[7:4]) begin
			rdata_r <= hsc_pkg::DATA_W'(acc_r[grp_idx]);
		end else if (addr == hsc_pkg::STAT_OFS) begin
			rdata_r <= hsc_pkg::DATA_W'({lvl, compare_output_two_r, compare_output_one_r});
		end else begin
			rdata_r <= '0;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_clear_holds: assert property (mode[0] == hsc_pkg::M_TOTAL && prog_ctrl_r[0] // see R5
		|=> acc_r[0] == '0) else $error("clear did not zero totalizer");
	a_hw_reset: assert property (hw_rst[1] && mode[1] == hsc_pkg::M_TOTAL // see R7
		|-> ##[1:2] acc_r[1] == '0) else $error("hardware reset late");
	a_total_inc: assert property (mode[0] == hsc_pkg::M_TOTAL && tot_ev[0] // see R3
		&& !prog_ctrl_r[0] && !hw_rst[0] && mod_r[0] == '0
		|=> acc_r[0] == $past(acc_r[0]) + 1'b1) else $error("totalize step wrong");
	a_total_wrap: assert property (mode[0] == hsc_pkg::M_TOTAL && tot_ev[0] // see R4
		&& !prog_ctrl_r[0] && !hw_rst[0] && mod_r[0] != '0 && acc_r[0] == mod_r[0] - 1'b1
		|=> acc_r[0] == '0) else $error("totalize wrap wrong");
	a_cmp_zero: assert property (preset_r[0] == '0 |=> !compare_output_one_r) // see R9
		else $error("compare high with zero preset");
	a_cmp_high: assert property (mode[1] == hsc_pkg::M_TOTAL // see R8
		&& cfg_r[1][hsc_pkg::CFG_CMPEN_BIT] && preset_r[1] != '0 && acc_r[1] >= preset_r[1]
		|=> compare_output_two_r) else $error("compare output missed");
	a_tick_rate: assert property (tick_r |=> !tick_r [*8]) // see R25
		else $error("tick too fast");
	a_quad_down: assert property (q_dn[2] && !prog_ctrl_r[2] && !prog_ctrl_r[3] // see R15
		&& acc_r[2] == '0 |=> acc_r[2] == $past(mod_r[2]) - 1'b1)
		else $error("quadrature underflow wrong");
	a_quad_set: assert property (mode[0] == hsc_pkg::M_QUAD && !prog_ctrl_r[0] // see R16
		&& prog_ctrl_r[1] |=> acc_r[0] == $past(mod_r[0]) - 1'b1)
		else $error("quadrature set wrong");
	a_marker_load: assert property (mk_ld && !prog_ctrl_r[0] && !prog_ctrl_r[1] && mk_zero // see R18
		|=> acc_r[0] == '0) else $error("marker did not zero");

	c_freq_update: cover property (mode[0] == hsc_pkg::M_FREQ && win_end[0] && edges_r[0] != '0);
	c_pulse_latch: cover property (mode[1] == hsc_pkg::M_PULSE && p_stop[1] && cnt_r[1] != '0);
	c_marker_sync: cover property (mk_ld && !mk_zero);
	c_cmp_rise:    cover property (!compare_output_one_r ##1 compare_output_one_r);
endmodule

// ### rtl/hsc_in_sync.sv
`timescale 1ns/1ps
module hsc_in_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level_r,
	output logic      [WIDTH-1:0] rise_r,
	output logic      [WIDTH-1:0] fall_r
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] agree;

	assign agree = ~(s2_r ^ s3_r);

	// ==========================================================
	// Three-flop chain
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// ==========================================================
	// Accepted level and one-cycle edge pulses aligned to it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_r <= '0;
			rise_r  <= '0;
			fall_r  <= '0;
		end else begin
			level_r <= (level_r & ~agree) | (s3_r & agree); // see R24
			rise_r  <= agree & s3_r & ~level_r;
			fall_r  <= agree & ~s3_r & level_r;
		end
	end
endmodule

// ### rtl/hsc_pkg.sv
package hsc_pkg;
	localparam int NCH    = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CFG_W  = 11;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] CFG_BASE    = 8'h00;
	localparam logic [7:0] MOD_BASE    = 8'h10;
	localparam logic [7:0] PRESET_BASE = 8'h20;
	localparam logic [7:0] CTRL_OFS    = 8'h28;
	localparam logic [7:0] ACC_BASE    = 8'h30;
	localparam logic [7:0] STAT_OFS    = 8'h40;
	// ==========================================================
	// Configuration word fields
	localparam int CFG_MODE_LSB  = 0;
	localparam int CFG_MODE_W    = 3;
	localparam int CFG_SUB_LSB   = 4;
	localparam int CFG_SUB_W     = 2;
	localparam int CFG_QUP_BIT   = 6;
	localparam int CFG_MLVL_BIT  = 7;
	localparam int CFG_MPH_BIT   = 8;
	localparam int CFG_MFALL_BIT = 9;
	localparam int CFG_CMPEN_BIT = 10;
	localparam logic [CFG_W-1:0] CFG_RESET = 11'h000;
	// Program control word bits
	localparam int PROG_CLEAR_BIT_ONE  = 0;
	localparam int PROG_CTRL_BIT_TWO   = 1;
	localparam int PROG_CTRL_BIT_THREE = 2;
	localparam int PROG_CTRL_BIT_FOUR  = 3;
	// ==========================================================
	// Timing
	localparam int CLK_NS      = 8;
	localparam int TICK_NS     = 1000;
	localparam int TICK_CYC    = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int US_PER_SEC  = 1_000_000;
	localparam int HWRST_LAT_US = 100;
	localparam int MARK_LAT_US  = 50;
	// ==========================================================
	// Modes
	typedef enum logic [2:0] {
		M_OFF, M_FREQ, M_TOTAL, M_PULSE, M_QUAD, M_TRESET, M_MARKER
	} mode_type;
	typedef enum logic [1:0] {P_WHIGH, P_WLOW, P_PRISE, P_PFALL} pulse_type;
	typedef enum logic [1:0] {MK_RISE, MK_FALL, MK_BOTH, MK_SYNC} marker_type;
endpackage
